//--- hw/uhft_frame_timer.sv
// Frame remaining down counter and frame number counter
`timescale 1ns/10ps
module uhft_frame_timer (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [13:0] frameInterval,
   output logic      [13:0] frameRemaining,
   output logic      [15:0] frameNumber,
   output logic             sofPulse
);
   // Interval is sampled only at the wrap, so a mid-frame write waits
   always_ff @(posedge mclk) begin
      if (rst) begin
         frameRemaining <= uhft_pkg::FRAME_INTERVAL_RST;
         sofPulse       <= 1'b0;
      end else if (frameRemaining == 14'h0000) begin
         frameRemaining <= frameInterval; // [RULE2]
         sofPulse       <= 1'b1;
      end else begin
         frameRemaining <= frameRemaining - 14'h0001; // [RULE1]
         sofPulse       <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         frameNumber <= 16'h0000;
      end else if (frameRemaining == 14'h0000) begin
         frameNumber <= frameNumber + 16'h0001; // [RULE3] [RULE4]
      end
   end
endmodule : uhft_frame_timer

//--- hw/uhft_pkg.sv
// Shared constants and carrier types for the frame timing and root hub block
// How it works
// RULE1 - A 14-bit down counter holds the bit times left in this frame
// RULE2 - Frame length comes from a 14-bit interval, applied only at the next SOF
// RULE3 - A 16-bit frame number counter is the shared timing reference
// RULE4 - Frame number steps by one per frame, wraps to zero, read only
// RULE5 - Driver software may extend the frame number to a 32-bit count
// RULE6 - A 14-bit periodic start value sets when periodic work may begin
// RULE7 - Once remaining time reaches periodic start, periodic work wins until frame end
// RULE8 - A low-speed threshold decides if an 8-byte low-speed packet still fits
// RULE9 - Low-speed start allowed only while remaining count is at least the threshold; the registered flag stays set for one cycle at threshold minus one
// RULE10 - Software writes zero to reserved bits and ignores their read value
// RULE11 - Driver supplies descriptor length, type and hub current itself
// RULE12 - Root hub description spans two registers; the first holds hardware fields
// RULE13 - Bits 31:24 give the power-on to power-good wait in 2 ms steps
// RULE14 - A descriptor bit tells whether over-current protection exists
// RULE15 - A descriptor bit tells whether ports are switched or always powered
// RULE16 - With no-power-switching set, every port is powered
// RULE17 - Otherwise the mode bit picks global or per-port switching
// RULE18 - Masks ignored in global mode; masked ports obey only per-port commands
package uhft_pkg;
   localparam int          PORTS              = 3;
   localparam logic [31:0] ADDR_FRAME_INTERVAL = 32'h4C000034;
   localparam logic [31:0] ADDR_FRAME_REMAIN  = 32'h4C000038;
   localparam logic [31:0] ADDR_FRAME_NUMBER  = 32'h4C00003C;
   localparam logic [31:0] ADDR_PERIODIC      = 32'h4C000040;
   localparam logic [31:0] ADDR_LS_THRESHOLD  = 32'h4C000044;
   localparam logic [31:0] ADDR_HUB_DESC_A    = 32'h4C000048;
   localparam logic [31:0] ADDR_POWER_CMD     = 32'h4C000060;
   localparam logic [31:0] ADDR_POWER_MASK    = 32'h4C000064;
   localparam logic [13:0] FRAME_INTERVAL_RST = 14'h2EDF;
   localparam logic [13:0] PERIODIC_RST       = 14'h0000;
   localparam logic [11:0] LS_THRESHOLD_RST   = 12'h628;
   localparam logic [7:0]  POWER_GOOD_RST     = 8'h02;
   localparam logic [7:0]  PORT_COUNT_VAL     = 8'h02;
   localparam int          POWER_GOOD_LSB     = 24;
   localparam int          NO_OVERCURRENT_PROTECTION_BIT           = 12;
   localparam int          OVERCURRENT_REPORT_MODE_BIT           = 11;
   localparam int          DT_BIT             = 10;
   localparam int          NPS_BIT            = 9;
   localparam int          PSM_BIT            = 8;
   localparam int          CMD_SET_GLOBAL     = 0;
   localparam int          CMD_CLR_GLOBAL     = 1;
   localparam int          CMD_SET_PORT_LSB   = 8;
   localparam int          CMD_CLR_PORT_LSB   = 16;

   typedef struct packed {
      logic [7:0] powerGoodWait;
      logic       noOvercurrentProtection;
      logic       overcurrentReportMode;
      logic       noPowerSwitching;
      logic       powerSwitchingMode;
   } uhft_hub_cfg_t;

   typedef struct packed {
      logic             setGlobal;
      logic             clrGlobal;
      logic [PORTS-1:0] setPort;
      logic [PORTS-1:0] clrPort;
   } uhft_pwr_cmd_t;

   typedef enum logic [1:0] {
      APB_IDLE   = 2'b01,
      APB_ACCESS = 2'b10
   } uhft_apb_state_t;
endpackage : uhft_pkg

//--- hw/uhft_port_power.sv
// Port power state for each downstream port
`timescale 1ns/10ps
module uhft_port_power #(
   parameter int PORTS = uhft_pkg::PORTS
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   noPowerSwitching,
   input  wire logic                   powerSwitchingMode,
   input  wire logic       [PORTS-1:0] powerMask,
   input  wire logic                   setGlobal,
   input  wire logic                   clrGlobal,
   input  wire logic       [PORTS-1:0] setPort,
   input  wire logic       [PORTS-1:0] clrPort,
   output logic            [PORTS-1:0] portPower
);
   genvar i;
   generate
      for (i = 0; i < PORTS; i++) begin : g_port
         always_ff @(posedge mclk) begin
            if (rst) begin
               portPower[i] <= 1'b0;
            end else if (noPowerSwitching) begin
               portPower[i] <= 1'b1; // [RULE16]
            end else if (powerSwitchingMode && powerMask[i]) begin
               // Masked port listens to its own command only
               if (setPort[i]) begin
                  portPower[i] <= 1'b1; // [RULE18]
               end else if (clrPort[i]) begin
                  portPower[i] <= 1'b0; // [RULE18]
               end
            end else begin
               if (setGlobal) begin
                  portPower[i] <= 1'b1; // [RULE17]
               end else if (clrGlobal) begin
                  portPower[i] <= 1'b0; // [RULE17]
               end
            end
         end
      end
   endgenerate
endmodule : uhft_port_power

//--- hw/uhft_top.sv
// Frame timing and first root hub descriptor with APB register access
`timescale 1ns/10ps
module uhft_top (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                paddr,
   input  wire logic [31:0]                pwdata,
   output logic                            pready,
   output logic      [31:0]                prdata,
   output logic                            pslverr,
   output logic      [13:0]                frameRemaining,
   output logic      [15:0]                frameNumber,
   output logic                            sofPulse,
   output logic                            periodicPriority,
   output logic                            lowSpeedStartOk,
   output logic                            overcurrentProtected,
   output logic                            overcurrentPerPort,
   output logic      [uhft_pkg::PORTS-1:0] portPower
);
   localparam int P = uhft_pkg::PORTS;

   uhft_pkg::uhft_apb_state_t apbState;
   uhft_pkg::uhft_hub_cfg_t   hubCfg;
   uhft_pkg::uhft_pwr_cmd_t   powerCmd;
   uhft_pkg::uhft_pwr_cmd_t   next_powerCmd;
   logic [13:0]               frameInterval;
   logic [13:0]               periodicStart;
   logic [11:0]               lsThreshold;
   logic [P-1:0]              powerMask;
   logic [31:0]               next_prdata;
   logic                      next_slverr;
   logic                      wrEn;
   logic                      setupPhase;

   assign setupPhase = psel && !penable;
   // Writes land only on the edge where the access phase completes
   assign wrEn = psel && penable && pready && pwrite;

   // Bus phase tracking; one wait-free access cycle follows each setup
   always_ff @(posedge mclk) begin
      if (rst) begin
         apbState <= uhft_pkg::APB_IDLE;
      end else begin
         case (apbState)
            uhft_pkg::APB_IDLE: begin
               if (setupPhase) begin
                  apbState <= uhft_pkg::APB_ACCESS;
               end
            end
            uhft_pkg::APB_ACCESS: begin
               apbState <= uhft_pkg::APB_IDLE;
            end
            default: begin
               apbState <= uhft_pkg::APB_IDLE;
            end
         endcase
      end
   end

   // Ready and data are registered in setup so every output stays a flop
   always_ff @(posedge mclk) begin
      if (rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (apbState == uhft_pkg::APB_IDLE && setupPhase) begin
         pready  <= 1'b1;
         prdata  <= pwrite ? 32'h00000000 : next_prdata;
         pslverr <= next_slverr;
      end else begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

   // Read mux; reserved bits read as zero
   always_comb begin
      next_prdata = 32'h00000000;
      next_slverr = 1'b0;
      case (paddr)
         uhft_pkg::ADDR_FRAME_INTERVAL: next_prdata[13:0] = frameInterval;
         uhft_pkg::ADDR_FRAME_REMAIN:   next_prdata[13:0] = frameRemaining;
         uhft_pkg::ADDR_FRAME_NUMBER:   next_prdata[15:0] = frameNumber; // [RULE3]
         uhft_pkg::ADDR_PERIODIC:       next_prdata[13:0] = periodicStart;
         uhft_pkg::ADDR_LS_THRESHOLD:   next_prdata[11:0] = lsThreshold;
         uhft_pkg::ADDR_HUB_DESC_A: begin
            next_prdata[uhft_pkg::POWER_GOOD_LSB +: 8] = hubCfg.powerGoodWait; // [RULE12]
            next_prdata[uhft_pkg::NO_OVERCURRENT_PROTECTION_BIT] = hubCfg.noOvercurrentProtection; // [RULE14]
            next_prdata[uhft_pkg::OVERCURRENT_REPORT_MODE_BIT] = hubCfg.overcurrentReportMode;
            next_prdata[uhft_pkg::DT_BIT]   = 1'b0;
            next_prdata[uhft_pkg::NPS_BIT]  = hubCfg.noPowerSwitching; // [RULE15]
            next_prdata[uhft_pkg::PSM_BIT]  = hubCfg.powerSwitchingMode;
            next_prdata[7:0]                = uhft_pkg::PORT_COUNT_VAL;
         end
         uhft_pkg::ADDR_POWER_CMD:      next_prdata[P-1:0] = portPower;
         uhft_pkg::ADDR_POWER_MASK:     next_prdata[P-1:0] = powerMask;
         default:                       next_slverr = 1'b1;
      endcase
   end

   // A new interval is only held here; the timer picks it up at SOF
   always_ff @(posedge mclk) begin
      if (rst) begin
         frameInterval <= uhft_pkg::FRAME_INTERVAL_RST;
      end else if (wrEn && paddr == uhft_pkg::ADDR_FRAME_INTERVAL) begin
         frameInterval <= pwdata[13:0]; // [RULE2]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         periodicStart <= uhft_pkg::PERIODIC_RST;
      end else if (wrEn && paddr == uhft_pkg::ADDR_PERIODIC) begin
         periodicStart <= pwdata[13:0]; // [RULE6]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lsThreshold <= uhft_pkg::LS_THRESHOLD_RST;
      end else if (wrEn && paddr == uhft_pkg::ADDR_LS_THRESHOLD) begin
         lsThreshold <= pwdata[11:0]; // [RULE8]
      end
   end

   // Device type and port count are fixed; the rest is software writable
   always_ff @(posedge mclk) begin
      if (rst) begin
         hubCfg.powerGoodWait           <= uhft_pkg::POWER_GOOD_RST;
         hubCfg.noOvercurrentProtection <= 1'b0;
         hubCfg.overcurrentReportMode   <= 1'b0;
         hubCfg.noPowerSwitching        <= 1'b0;
         hubCfg.powerSwitchingMode      <= 1'b0;
      end else if (wrEn && paddr == uhft_pkg::ADDR_HUB_DESC_A) begin
         hubCfg.powerGoodWait           <= pwdata[uhft_pkg::POWER_GOOD_LSB +: 8];
         hubCfg.noOvercurrentProtection <= pwdata[uhft_pkg::NO_OVERCURRENT_PROTECTION_BIT]; // [RULE14]
         hubCfg.overcurrentReportMode   <= pwdata[uhft_pkg::OVERCURRENT_REPORT_MODE_BIT];
         hubCfg.noPowerSwitching        <= pwdata[uhft_pkg::NPS_BIT]; // [RULE15]
         hubCfg.powerSwitchingMode      <= pwdata[uhft_pkg::PSM_BIT]; // [RULE17]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         powerMask <= '0;
      end else if (wrEn && paddr == uhft_pkg::ADDR_POWER_MASK) begin
         powerMask <= pwdata[P-1:0];
      end
   end

   // Power commands live for one cycle only
   always_comb begin
      next_powerCmd = '0;
      if (wrEn && paddr == uhft_pkg::ADDR_POWER_CMD) begin
         next_powerCmd.setGlobal = pwdata[uhft_pkg::CMD_SET_GLOBAL];
         next_powerCmd.clrGlobal = pwdata[uhft_pkg::CMD_CLR_GLOBAL];
         next_powerCmd.setPort   = pwdata[uhft_pkg::CMD_SET_PORT_LSB +: P];
         next_powerCmd.clrPort   = pwdata[uhft_pkg::CMD_CLR_PORT_LSB +: P];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         powerCmd <= '0;
      end else begin
         powerCmd <= next_powerCmd;
      end
   end

   // Comparator outputs lag the counter by one cycle
   always_ff @(posedge mclk) begin
      if (rst) begin
         periodicPriority <= 1'b0;
      end else if (sofPulse) begin
         periodicPriority <= 1'b0;
      end else if (frameRemaining <= periodicStart) begin
         periodicPriority <= 1'b1; // [RULE7]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         lowSpeedStartOk <= 1'b0;
      end else begin
         lowSpeedStartOk <= frameRemaining >= {2'b00, lsThreshold}; // [RULE9]
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         overcurrentProtected <= 1'b0;
         overcurrentPerPort   <= 1'b0;
      end else begin
         overcurrentProtected <= !hubCfg.noOvercurrentProtection; // [RULE14]
         overcurrentPerPort   <= !hubCfg.noOvercurrentProtection
                                 && hubCfg.overcurrentReportMode;
      end
   end

   uhft_frame_timer u_timer (
      .mclk           (mclk),
      .rst            (rst),
      .frameInterval  (frameInterval),
      .frameRemaining (frameRemaining),
      .frameNumber    (frameNumber),
      .sofPulse       (sofPulse)
   );

   uhft_port_power #(
      .PORTS (P)
   ) u_power (
      .mclk               (mclk),
      .rst                (rst),
      .noPowerSwitching   (hubCfg.noPowerSwitching),
      .powerSwitchingMode (hubCfg.powerSwitchingMode),
      .powerMask          (powerMask),
      .setGlobal          (powerCmd.setGlobal),
      .clrGlobal          (powerCmd.clrGlobal),
      .setPort            (powerCmd.setPort),
      .clrPort            (powerCmd.clrPort),
      .portPower          (portPower)
   );

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sequence s_wrap;
      frameRemaining == 14'h0000;
   endsequence

   sequence s_globalOn;
      !hubCfg.noPowerSwitching && !hubCfg.powerSwitchingMode && powerCmd.setGlobal;
   endsequence

   sequence s_maskedGlobal;
      !hubCfg.noPowerSwitching && hubCfg.powerSwitchingMode
      && (powerCmd.setGlobal || powerCmd.clrGlobal)
      && powerCmd.setPort == '0 && powerCmd.clrPort == '0;
   endsequence

   // Reset is sampled high on its release edge, so that edge starts no check
   a_count_down: assert property ( // [RULE1]
      !rst && frameRemaining != 14'h0000
      |=> frameRemaining == $past(frameRemaining) - 14'h0001)
      else $error("frame remaining did not count down");

   a_interval_reload: assert property ( // [RULE2]
      s_wrap |=> frameRemaining == $past(frameInterval) && sofPulse)
      else $error("interval not reloaded at frame wrap");

   a_number_advance: assert property ( // [RULE4]
      sofPulse |-> frameNumber == $past(frameNumber) + 16'h0001)
      else $error("frame number did not advance by one");

   a_number_steady: assert property ( // [RULE3]
      !rst && !sofPulse |-> $stable(frameNumber))
      else $error("frame number moved inside a frame");

   a_periodic_hold: assert property ( // [RULE6]
      !rst && $changed(periodicStart) |-> $past(wrEn && paddr == uhft_pkg::ADDR_PERIODIC))
      else $error("periodic start changed without a write");

   a_periodic_wins: assert property ( // [RULE7]
      frameRemaining <= periodicStart && !sofPulse |=> periodicPriority ##1
      (periodicPriority || $past(sofPulse)))
      else $error("periodic priority not held");

   a_lowspeed_gate: assert property ( // [RULE9]
      lowSpeedStartOk |-> $past(frameRemaining) >= {2'b00, $past(lsThreshold)})
      else $error("low-speed start allowed below threshold");

   a_ocp_flag: assert property ( // [RULE14]
      !rst |=> overcurrentProtected != $past(hubCfg.noOvercurrentProtection))
      else $error("over-current protection flag wrong");

   a_always_powered: assert property ( // [RULE16]
      hubCfg.noPowerSwitching |=> portPower == '1)
      else $error("port unpowered without switching");

   a_global_on: assert property ( // [RULE17]
      s_globalOn |=> portPower == '1)
      else $error("global power command not applied");

   a_mask_global: assert property ( // [RULE18]
      s_maskedGlobal |=> (portPower & powerMask) == ($past(portPower) & $past(powerMask)))
      else $error("masked port followed a global command");

   a_desc_read: assert property ( // [RULE12]
      pready && !pwrite && paddr == uhft_pkg::ADDR_HUB_DESC_A
      |-> prdata[uhft_pkg::DT_BIT] == 1'b0 && prdata[7:0] == uhft_pkg::PORT_COUNT_VAL)
      else $error("descriptor fixed fields wrong");
endmodule : uhft_top

//--- sim/uhft_port_dev.sv
// Model of the devices that sit on the downstream ports
`timescale 1ns/10ps
module uhft_port_dev (
   input  wire logic                       mclk,
   input  wire logic                       rst,
   input  wire logic [uhft_pkg::PORTS-1:0] portPower,
   output logic      [7:0]                 powerUps
);
   logic [uhft_pkg::PORTS-1:0] seen;
   // A device only notices a supply step, so count rising power per port
   always_ff @(posedge mclk) begin
      if (rst) begin
         seen     <= '0;
         powerUps <= 8'h00;
      end else begin
         seen     <= portPower;
         powerUps <= powerUps + 8'($countones(portPower & ~seen));
      end
   end
endmodule : uhft_port_dev

//--- sim/uhft_top_tb_top.sv
// Self-checking bench for the frame timing and root hub block
`timescale 1ns/10ps
module uhft_top_tb_top;
   logic                       mclk = 1'b0;
   logic                       rst = 1'b1;
   logic                       psel = 1'b0;
   logic                       penable = 1'b0;
   logic                       pwrite = 1'b0;
   logic [31:0]                paddr = 32'h0;
   logic [31:0]                pwdata = 32'h0;
   logic                       pready;
   logic [31:0]                prdata;
   logic                       pslverr;
   logic [13:0]                frameRemaining;
   logic [15:0]                frameNumber;
   logic                       sofPulse;
   logic                       periodicPriority;
   logic                       lowSpeedStartOk;
   logic                       overcurrentProtected;
   logic                       overcurrentPerPort;
   logic [uhft_pkg::PORTS-1:0] portPower;
   logic [7:0]                 powerUps;
   logic [31:0]                rd;
   logic                       er;
   logic [31:0]                sofCount;
   int                         fail_count = 0;
   int                         n_checks = 0;
   int                         cyc;

   always #5 mclk = ~mclk;

   uhft_top i_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .frameRemaining(frameRemaining), .frameNumber(frameNumber), .sofPulse(sofPulse),
      .periodicPriority(periodicPriority), .lowSpeedStartOk(lowSpeedStartOk),
      .overcurrentProtected(overcurrentProtected), .overcurrentPerPort(overcurrentPerPort),
      .portPower(portPower));

   uhft_port_dev i_dev (.mclk(mclk), .rst(rst), .portPower(portPower), .powerUps(powerUps));

   // Software view of time: frame number stretched to 32 bits
   always @(posedge mclk) begin
      if (rst) begin
         sofCount <= 32'h0;
      end else if (sofPulse === 1'b1) begin
         sofCount <= sofCount + 32'h1;
      end
   end

   task automatic end_of_test();
      if (fail_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic hang();
      chk(32'h0, 32'h1);
      end_of_test();
   endtask : hang

   // Request is held until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (n > 20) hang();
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0);
   endtask : rdchk

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Port power settles one edge after the write edge
   task automatic pwr(input logic [31:0] c, input logic [2:0] exp);
      wr(uhft_pkg::ADDR_POWER_CMD, c);
      repeat (3) @(negedge mclk);
      chk({29'h0, portPower}, {29'h0, exp});
   endtask : pwr

   task automatic wait_rem(input logic [13:0] v);
      cyc = 0;
      do begin
         @(negedge mclk);
         cyc++;
         if (cyc > 14000) hang();
      end while (frameRemaining !== v);
   endtask : wait_rem

   task automatic wait_sof();
      cyc = 0;
      do begin
         @(negedge mclk);
         cyc++;
         if (cyc > 14000) hang();
      end while (sofPulse !== 1'b1);
   endtask : wait_sof

   task automatic do_reset();
      @(posedge mclk);
      rst <= 1'b1;
      @(posedge mclk);
      @(negedge mclk);
      chk(frameRemaining, uhft_pkg::FRAME_INTERVAL_RST);
      chk({27'h0, portPower, sofPulse, pready}, 32'h0);
      @(posedge mclk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic t_regs();
      rdchk(uhft_pkg::ADDR_PERIODIC, 32'h0);
      rdchk(uhft_pkg::ADDR_LS_THRESHOLD, 32'h628);
      rdchk(uhft_pkg::ADDR_HUB_DESC_A, 32'h02000002);
      rdchk(uhft_pkg::ADDR_FRAME_NUMBER, 32'h0);
      apb(1'b0, 32'h4C000070, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      wr(uhft_pkg::ADDR_PERIODIC, 32'h3FFF);
      rdchk(uhft_pkg::ADDR_PERIODIC, 32'h3FFF);
      wr(uhft_pkg::ADDR_LS_THRESHOLD, 32'hFFF);
      rdchk(uhft_pkg::ADDR_LS_THRESHOLD, 32'hFFF);
      wr(uhft_pkg::ADDR_FRAME_NUMBER, 32'h1234);
      rdchk(uhft_pkg::ADDR_FRAME_NUMBER, 32'h0);
   endtask : t_regs

   // A short interval written mid-frame must wait for the next SOF
   task automatic t_frame();
      wr(uhft_pkg::ADDR_FRAME_INTERVAL, 32'h20);
      apb(1'b0, uhft_pkg::ADDR_FRAME_REMAIN, 32'h0);
      chk({31'h0, rd[13:0] > 14'h2E00}, 32'h1);
      wait_sof();
      chk(frameRemaining, 14'h20);
      chk(frameNumber, 16'h1);
      wait_sof();
      chk(cyc, 33);
      chk(frameNumber, 16'h2);
   endtask : t_frame

   task automatic t_sched();
      wr(uhft_pkg::ADDR_PERIODIC, 32'h10);
      wr(uhft_pkg::ADDR_LS_THRESHOLD, 32'h18);
      wait_sof();
      wait_rem(14'h1E);
      chk({31'h0, periodicPriority}, 32'h0);
      chk(frameNumber, sofCount[15:0]);
      wait_rem(14'h17);
      chk({31'h0, lowSpeedStartOk}, 32'h1);
      wait_rem(14'h16);
      chk({31'h0, lowSpeedStartOk}, 32'h0);
      wait_rem(14'h11);
      chk({31'h0, periodicPriority}, 32'h0);
      wait_rem(14'h0E);
      chk({31'h0, periodicPriority}, 32'h1);
      wait_rem(14'h0);
      chk({31'h0, periodicPriority}, 32'h1);
   endtask : t_sched

   task automatic t_power();
      wr(uhft_pkg::ADDR_HUB_DESC_A, 32'hFF001F07);
      rdchk(uhft_pkg::ADDR_HUB_DESC_A, 32'hFF001B02);
      repeat (2) @(negedge mclk);
      chk({31'h0, overcurrentProtected}, 32'h0);
      chk({29'h0, portPower}, 32'h7);
      rdchk(uhft_pkg::ADDR_POWER_CMD, 32'h7);
      wr(uhft_pkg::ADDR_HUB_DESC_A, 32'h02000800);
      pwr(32'h2, 3'b000);
      chk({30'h0, overcurrentProtected, overcurrentPerPort}, 32'h3);
      pwr(32'h700, 3'b000);
      pwr(32'h1, 3'b111);
      pwr(32'h2, 3'b000);
      wr(uhft_pkg::ADDR_POWER_MASK, 32'h2);
      wr(uhft_pkg::ADDR_HUB_DESC_A, 32'h02000100);
      pwr(32'h1, 3'b101);
      pwr(32'h200, 3'b111);
      pwr(32'h2, 3'b010);
      pwr(32'h20000, 3'b000);
      chk({30'h0, overcurrentProtected, overcurrentPerPort}, 32'h2);
      chk(powerUps, 8'h09);
   endtask : t_power

   // One-cycle frames make the 16-bit wrap reachable in a short run
   task automatic t_wrap();
      int n;
      n = 0;
      wr(uhft_pkg::ADDR_FRAME_INTERVAL, 32'h0);
      do begin
         @(negedge mclk);
         n++;
         if (n > 70000) hang();
      end while (frameNumber !== 16'hFFFF);
      @(negedge mclk);
      chk(frameNumber, 16'h0);
   endtask : t_wrap

   initial begin
      do_reset();
      t_regs();
      t_frame();
      t_sched();
      t_power();
      t_wrap();
      do_reset();
      rdchk(uhft_pkg::ADDR_HUB_DESC_A, 32'h02000002);
      rdchk(uhft_pkg::ADDR_PERIODIC, 32'h0);
      end_of_test();
   end
endmodule : uhft_top_tb_top
